// file: pkg/ecgsi_pkg.sv
package ecgsi_pkg;

  localparam logic [6:0] ADDR_NOP_LO = 7'h00;
  localparam logic [6:0] ADDR_STATUS = 7'h01;
  localparam logic [6:0] ADDR_RTOR = 7'h25;
  localparam logic [6:0] ADDR_NOP_HI = 7'h7F;

  localparam int CMD_LAST_EDGE = 7;
  localparam int FRAME_LAST_EDGE = 31;

  localparam int CLOCK_MHZ = 100;
  localparam int LEADS_OFF_TIME_MS = 115;
  localparam int LEADS_OFF_CYCLES = LEADS_OFF_TIME_MS * 1000 * CLOCK_MHZ;
  localparam logic [1:0] R_EVENT_LAST_QUARTER = 2'h3;

  localparam logic [1:0] ULP_MODE_A = 2'h1;
  localparam logic [1:0] ULP_MODE_B = 2'h2;
  localparam logic [1:0] R_CLR_STATUS = 2'h0;
  localparam logic [1:0] R_CLR_RTOR = 2'h1;
  localparam logic [1:0] R_CLR_SELF = 2'h2;

  localparam logic [4:0] FIFO_THRESHOLD_RESET = 5'h0F;
  localparam logic SAMPLE_CLEAR_RESET = 1'b1;

  typedef enum logic [1:0] {
    LK_CMD = 2'b00,
    LK_RD = 2'b01,
    LK_WR = 2'b10,
    LK_END = 2'b11
  } ecgsi_link_e;

  typedef struct packed {
    logic fifo_thr;
    logic fifo_ovf;
    logic fast;
    logic dc_off;
    logic leads_on;
    logic r_event;
    logic sample;
    logic pll_unlock;
    logic [3:0] detail;
  } ecgsi_terms_s;

  typedef struct packed {
    logic [5:0] fifo_unread_count;
    logic fifo_overflow_pulse;
    logic fifo_reset_pulse;
    logic synchronize_command;
    logic fast_active;
    logic dc_leads_off_raw;
    logic [3:0] detail_raw;
    logic leads_on_raw;
    logic r_event_pulse;
    logic sample_tick;
    logic quarter_tick;
    logic pll_powered;
    logic pll_locked;
  } ecgsi_src_s;

  typedef struct packed {
    logic [4:0] fifo_threshold_field;
    logic fast_clear_select;
    logic [1:0] r_event_clear_select;
    logic sample_clear_select;
    logic [3:0] sample_interval_field;
    logic [1:0] ulp_leads_on_mode;
  } ecgsi_cfg_s;

endpackage

// file: design/ecgsi_sync.sv
`timescale 1ns/1ps
module ecgsi_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [1:0][W-1:0] s;
  logic [1:0][W-1:0] next_s;

  always_comb begin
    next_s = {s[0], d};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s[1];
endmodule

// file: design/ecgsi_spi_link.sv
`timescale 1ns/1ps
module ecgsi_spi_link (
  input wire logic sclk,
  input wire logic csb,
  input wire logic rst,
  input wire logic sdi,
  input wire logic [23:0] status_word,
  output logic sdo,
  output logic sdo_oe_n,
  output logic status_read_toggle,
  output logic rtor_read_toggle
);
  typedef struct packed {
    ecgsi_pkg::ecgsi_link_e state;
    logic [5:0] edges;
    logic [7:0] cmd;
    logic [23:0] shift;
    logic sdo;
  } ecgsi_link_s;

  ecgsi_link_s s;
  ecgsi_link_s next_s;
  logic [7:0] cmd_full;
  logic last_edge;
  logic [1:0] tg;

  always_comb begin
    next_s = s;
    cmd_full = {s.cmd[6:0], sdi};
    last_edge = (s.edges == 6'(ecgsi_pkg::FRAME_LAST_EDGE));
    next_s.edges = s.edges + 6'h01;
    unique case (s.state)
      ecgsi_pkg::LK_CMD: begin
        next_s.cmd = cmd_full;
        if (s.edges == 6'(ecgsi_pkg::CMD_LAST_EDGE)) begin
          if (cmd_full[0]) begin
            next_s.state = ecgsi_pkg::LK_RD;
            // Only the status register has content here; no_operation_high and others shift zero
            if (cmd_full[7:1] == ecgsi_pkg::ADDR_STATUS) begin
              next_s.sdo = status_word[23];
              next_s.shift = {status_word[22:0], 1'b0};
            end else begin
              next_s.sdo = 1'b0;
              next_s.shift = '0;
            end
          end else begin
            next_s.state = ecgsi_pkg::LK_WR;
          end
        end
      end
      ecgsi_pkg::LK_RD: begin
        next_s.sdo = s.shift[23];
        next_s.shift = {s.shift[22:0], 1'b0};
        if (last_edge) begin
          next_s.state = ecgsi_pkg::LK_END;
        end
      end
      ecgsi_pkg::LK_WR: begin
        // Write data is dropped for every address this block answers
        if (last_edge) begin
          next_s.state = ecgsi_pkg::LK_END;
        end
      end
      ecgsi_pkg::LK_END: begin
        next_s.edges = s.edges;
      end
    endcase
  end

  always_ff @(posedge sclk or posedge csb) begin
    if (csb) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Read-completion events cross as toggles; these survive frame end
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      tg <= 2'h0;
    end else if (s.state == ecgsi_pkg::LK_RD && last_edge) begin
      tg <= tg ^ {s.cmd[7:1] == ecgsi_pkg::ADDR_RTOR,
                  s.cmd[7:1] == ecgsi_pkg::ADDR_STATUS};
    end
  end

  assign status_read_toggle = tg[0];
  assign rtor_read_toggle = tg[1];
  assign sdo = s.sdo;
  assign sdo_oe_n = csb | (s.state != ecgsi_pkg::LK_RD);
endmodule

// file: design/ecgsi_status_top.sv
`timescale 1ns/1ps
module ecgsi_status_top #(
  parameter int LEADS_OFF_CYCLES = ecgsi_pkg::LEADS_OFF_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic csb,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe_n,
  input wire ecgsi_pkg::ecgsi_src_s src,
  input wire ecgsi_pkg::ecgsi_cfg_s cfg,
  output ecgsi_pkg::ecgsi_terms_s terms
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    ecgsi_pkg::ecgsi_terms_s terms;
    logic fast_prev;
    logic ulp_prev;
    logic leads_armed;
    logic [23:0] lo_timer;
    logic [1:0] r_quarters;
    logic [3:0] sample_pulse_term_count;
    logic [23:0] status_hold;
    logic csb_prev;
    logic stat_prev;
    logic rtor_prev;
  } ecgsi_ctl_s;

  localparam logic [23:0] LO_LIM = 24'(LEADS_OFF_CYCLES);

  function automatic logic [23:0] ecgsi_status_word(
    input ecgsi_pkg::ecgsi_terms_s t
  );
    logic [23:0] w;
    w = '0;
    w[23] = t.fifo_thr;
    w[22] = t.fifo_ovf;
    w[21] = t.fast;
    w[20] = t.dc_off;
    w[11] = t.leads_on;
    w[10] = t.r_event;
    w[9] = t.sample;
    w[8] = t.pll_unlock;
    w[3:0] = t.detail;
    return w;
  endfunction

  ecgsi_ctl_s s;
  ecgsi_ctl_s next_s;
  logic csb_sync;
  logic stat_sync;
  logic rtor_sync;
  logic rd;
  logic rtor_rd;
  logic mode_on;
  logic qual;
  logic fire;
  logic r_clr;
  logic sample_pulse_term_clr;
  logic [5:0] thr_count;
  logic [1:0] tg;
  logic [23:0] status_word;

  ////////////////////////////////////////////////////////////////////////////
  // Link side and crossings

  ecgsi_spi_link u_link (
    .sclk(sclk),
    .csb(csb),
    .rst(rst),
    .sdi(sdi),
    .status_word(status_word),
    .sdo(sdo),
    .sdo_oe_n(sdo_oe_n),
    .status_read_toggle(tg[0]),
    .rtor_read_toggle(tg[1])
  );

  ecgsi_sync #(
    .W(3)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .d({csb, tg}),
    .q({csb_sync, rtor_sync, stat_sync})
  );

  assign status_word = s.status_hold;
  assign terms = s.terms;

  ////////////////////////////////////////////////////////////////////////////
  // Term logic

  always_comb begin
    next_s = s;
    rd = stat_sync ^ s.stat_prev;
    rtor_rd = rtor_sync ^ s.rtor_prev;
    next_s.stat_prev = stat_sync;
    next_s.rtor_prev = rtor_sync;

    thr_count = {1'b0, cfg.fifo_threshold_field} + 6'h01;
    next_s.terms.fifo_thr = src.fifo_unread_count >= thr_count;

    if (src.fifo_reset_pulse || src.synchronize_command) begin
      next_s.terms.fifo_ovf = 1'b0;
    end
    if (src.fifo_overflow_pulse) begin
      next_s.terms.fifo_ovf = 1'b1;
    end

    next_s.fast_prev = src.fast_active;
    if (cfg.fast_clear_select) begin
      // Only a fresh entry sets it, so a cleared term stays low in recovery
      next_s.terms.fast = (src.fast_active & ~s.fast_prev) |
                          (s.terms.fast & ~rd);
    end else begin
      next_s.terms.fast = src.fast_active | (s.terms.fast & ~rd);
    end

    if (!src.dc_leads_off_raw) begin
      next_s.lo_timer = '0;
    end else if (s.lo_timer != LO_LIM) begin
      next_s.lo_timer = s.lo_timer + 24'h000001;
    end
    qual = src.dc_leads_off_raw && (s.lo_timer == LO_LIM);
    next_s.terms.dc_off = qual | (s.terms.dc_off & ~rd);
    next_s.terms.detail = ({4{qual}} & src.detail_raw) |
                          (s.terms.detail & {4{~rd}});

    mode_on = (cfg.ulp_leads_on_mode == ecgsi_pkg::ULP_MODE_A) ||
              (cfg.ulp_leads_on_mode == ecgsi_pkg::ULP_MODE_B);
    next_s.ulp_prev = mode_on;
    if (!mode_on) begin
      next_s.leads_armed = 1'b0;
    end else if (rd) begin
      next_s.leads_armed = 1'b1;
    end
    next_s.terms.leads_on = (mode_on & ~s.ulp_prev) |
                            (s.leads_armed & mode_on & src.leads_on_raw) |
                            (s.terms.leads_on & ~rd);

    unique case (cfg.r_event_clear_select)
      ecgsi_pkg::R_CLR_STATUS: r_clr = rd;
      ecgsi_pkg::R_CLR_RTOR: r_clr = rtor_rd;
      ecgsi_pkg::R_CLR_SELF: begin
        r_clr = src.quarter_tick &&
                (s.r_quarters == ecgsi_pkg::R_EVENT_LAST_QUARTER);
      end
      default: r_clr = rd;
    endcase
    if (src.r_event_pulse) begin
      next_s.r_quarters = 2'h0;
    end else if (s.terms.r_event && src.quarter_tick) begin
      next_s.r_quarters = s.r_quarters + 2'h1;
    end
    next_s.terms.r_event = src.r_event_pulse | (s.terms.r_event & ~r_clr);

    fire = src.sample_tick && (s.sample_pulse_term_count == cfg.sample_interval_field);
    if (fire) begin
      next_s.sample_pulse_term_count = 4'h0;
    end else if (src.sample_tick) begin
      next_s.sample_pulse_term_count = s.sample_pulse_term_count + 4'h1;
    end
    sample_pulse_term_clr = cfg.sample_clear_select ? src.quarter_tick : rd;
    next_s.terms.sample = fire | (s.terms.sample & ~sample_pulse_term_clr);

    next_s.terms.pll_unlock = (src.pll_powered & ~src.pll_locked) |
                              (s.terms.pll_unlock & ~rd);

    // Frame start freezes the word the link will shift out
    next_s.csb_prev = csb_sync;
    if (s.csb_prev && !csb_sync) begin
      next_s.status_hold = ecgsi_status_word(s.terms);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      // Edge detector starts low like its synchroniser: no false frame start
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_ovf_set: assert property (src.fifo_overflow_pulse |=> terms.fifo_ovf)
    else $error("overflow term not set");

  a_ovf_clear: assert property (
    (src.fifo_reset_pulse && !src.fifo_overflow_pulse) |=> !terms.fifo_ovf)
    else $error("overflow term not cleared");

  a_thr_level: assert property (
    (src.fifo_unread_count > {1'b0, cfg.fifo_threshold_field}) |=> terms.fifo_thr)
    else $error("threshold term missing");

  a_dc_off_late: assert property (
    $rose(terms.dc_off) |-> $past(s.lo_timer) == LO_LIM)
    else $error("leads-off term set early");

  a_pll_held: assert property (
    $fell(terms.pll_unlock) |-> $past(rd) && !$past(src.pll_powered & ~src.pll_locked))
    else $error("pll term dropped without read");

  a_pll_powered: assert property (
    $rose(terms.pll_unlock) |-> $past(src.pll_powered))
    else $error("pll term set while unpowered");

  a_sample_pulse_term_self: assert property (
    (cfg.sample_clear_select && terms.sample && src.quarter_tick && !fire)
    |=> !terms.sample)
    else $error("sample term did not self-clear");

  a_r_event_set: assert property (src.r_event_pulse |=> terms.r_event)
    else $error("r event term not set");

  a_r_rtor_clear: assert property (
    (cfg.r_event_clear_select == ecgsi_pkg::R_CLR_RTOR && terms.r_event && !rtor_rd)
    ##1 !src.r_event_pulse |-> terms.r_event)
    else $error("r event term cleared without interval read");

  a_ulp_entry: assert property ((mode_on && !s.ulp_prev) |=> terms.leads_on)
    else $error("leads-on term not set on mode entry");

  a_fast_no_again: assert property (
    (cfg.fast_clear_select && src.fast_active && s.fast_prev && !terms.fast)
    |=> !terms.fast)
    else $error("fast term re-asserted inside recovery");

  a_detail_with: assert property ($rose(|terms.detail) |-> terms.dc_off)
    else $error("detail bits set without leads-off term");

  a_status_zero: assert property (
    s.status_hold[19:12] == 8'h00 && s.status_hold[7:4] == 4'h0)
    else $error("unused status bits not zero");

  c_overflow: cover property (src.fifo_overflow_pulse ##1 terms.fifo_ovf);
  c_status_read: cover property (rd && terms.pll_unlock);
  c_leads_armed: cover property (s.leads_armed && src.leads_on_raw);
  c_r_self: cover property (
    cfg.r_event_clear_select == ecgsi_pkg::R_CLR_SELF && $fell(terms.r_event));

endmodule

// file: bench/ecgsi_host.sv
`timescale 1ns/1ps
module ecgsi_host (
  output logic sclk,
  output logic csb,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  initial begin
    sclk = 1'b0;
    csb = 1'b1;
    sdi = 1'b0;
  end
  // One frame: command byte then 24 data bits, read bits captured before the next rise
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd};
    rd = 24'h0;
    csb = 1'b0;
    #61.3;
    for (int i = 0; i < 32; i++) begin
      sdi = sh[31-i];
      #6;
      // An undriven data bit reads as unknown so the compare fails
      if (i >= 8) rd = {rd[22:0], sdo_oe_n ? 1'bx : sdo};
      sclk = 1'b1;
      #6;
      sclk = 1'b0;
    end
    #6;
    csb = 1'b1;
    // Released line shows the inverse of its last level
    sdi = ~sdi;
    #50;
  endtask
endmodule

// file: bench/ecg_status_interrupt_terms_tb_top.sv
`timescale 1ns/1ps
module ecg_status_interrupt_terms_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sclk, csb, sdi, sdo, sdo_oe_n;
  ecgsi_pkg::ecgsi_src_s src = '0;
  ecgsi_pkg::ecgsi_cfg_s cfg = '0;
  ecgsi_pkg::ecgsi_terms_s terms;
  ecgsi_pkg::ecgsi_terms_s exp = '0;
  int err_count = 0;
  int compares = 0;
  logic [23:0] rd;
  logic [7:0] nop [4] = '{8'h01, 8'hFF, 8'h00, 8'hFE};
  logic [4:0] f;
  logic [3:0] d;
  always #5 clock = ~clock;
  ecgsi_host i_ecgsi_host (.sclk(sclk), .csb(csb), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n));
  ecgsi_status_top #(.LEADS_OFF_CYCLES(20)) i_ecgsi_status_top (.clock(clock), .rst(rst),
    .sclk(sclk), .csb(csb), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .src(src), .cfg(cfg),
    .terms(terms));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] want);
    compares++;
    if (got !== want) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  function automatic logic [23:0] word(input ecgsi_pkg::ecgsi_terms_s t);
    return {t.fifo_thr, t.fifo_ovf, t.fast, t.dc_off, 8'h00, t.leads_on, t.r_event, t.sample,
      t.pll_unlock, 4'h0, t.detail};
  endfunction
  task automatic live();
    cyc(3);
    @(negedge clock);
    chk(word(terms), word(exp));
  endtask
  task automatic rdst();
    i_ecgsi_host.xfer(8'h03, 24'h0, rd);
    chk(rd, word(exp));
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    case (k)
      0: src.fifo_overflow_pulse <= 1'b1;
      1: src.fifo_reset_pulse <= 1'b1;
      2: src.synchronize_command <= 1'b1;
      3: src.r_event_pulse <= 1'b1;
      4: src.sample_tick <= 1'b1;
      default: src.quarter_tick <= 1'b1;
    endcase
    @(posedge clock);
    {src.fifo_overflow_pulse, src.fifo_reset_pulse, src.synchronize_command} <= 3'h0;
    {src.r_event_pulse, src.sample_tick, src.quarter_tick} <= 3'h0;
    cyc(2);
  endtask
  task automatic stop_test();
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #300us;
    err_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h6de0));
    cyc(5);
    rst <= 1'b0;
    live();
    chk({23'h0, sdo_oe_n}, 24'h1);
    @(posedge clock);
    src.pll_powered <= 1'b1;
    exp.pll_unlock = 1'b1;
    live();
    for (int i = 0; i < 4; i++) begin
      i_ecgsi_host.xfer(nop[i], 24'($urandom()), rd);
      if (nop[i][0]) chk(rd, 24'h0);
    end
    live();
    @(posedge clock);
    src.pll_locked <= 1'b1;
    live();
    rdst();
    exp.pll_unlock = 1'b0;
    live();
    @(posedge clock);
    src.pll_powered <= 1'b0;
    src.pll_locked <= 1'b0;
    live();
    for (int i = 0; i < 3; i++) begin
      f = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom());
      @(posedge clock);
      cfg.fifo_threshold_field <= f;
      src.fifo_unread_count <= {1'b0, f};
      live();
      @(posedge clock);
      src.fifo_unread_count <= {1'b0, f} + 6'h01;
      exp.fifo_thr = 1'b1;
      live();
      @(posedge clock);
      src.fifo_unread_count <= 6'h00;
      exp.fifo_thr = 1'b0;
      live();
    end
    for (int k = 1; k < 3; k++) begin
      pulse(0);
      exp.fifo_ovf = 1'b1;
      rdst();
      live();
      pulse(k);
      exp.fifo_ovf = 1'b0;
      live();
    end
    for (int s = 0; s < 3; s++) begin
      @(posedge clock);
      cfg.r_event_clear_select <= 2'(s);
      pulse(3);
      exp.r_event = 1'b1;
      live();
      if (s == 0) rdst();
      if (s == 1) i_ecgsi_host.xfer(8'h4B, 24'h0, rd);
      if (s == 2) begin
        repeat (3) pulse(5);
        live();
        pulse(5);
      end
      exp.r_event = 1'b0;
      live();
    end
    @(posedge clock);
    cfg.sample_interval_field <= 4'h1;
    cfg.sample_clear_select <= 1'b1;
    pulse(4);
    live();
    pulse(4);
    exp.sample = 1'b1;
    live();
    pulse(5);
    exp.sample = 1'b0;
    live();
    @(posedge clock);
    cfg.sample_clear_select <= 1'b0;
    repeat (2) pulse(4);
    pulse(5);
    exp.sample = 1'b1;
    live();
    rdst();
    exp.sample = 1'b0;
    live();
    d = 4'($urandom());
    @(posedge clock);
    src.detail_raw <= d;
    src.dc_leads_off_raw <= 1'b1;
    cyc(10);
    live();
    cyc(15);
    exp.dc_off = 1'b1;
    exp.detail = d;
    live();
    @(posedge clock);
    src.detail_raw <= 4'h0;
    src.dc_leads_off_raw <= 1'b0;
    live();
    rdst();
    exp.dc_off = 1'b0;
    exp.detail = 4'h0;
    live();
    for (int m = 1; m < 3; m++) begin
      @(posedge clock);
      cfg.ulp_leads_on_mode <= 2'(m);
      exp.leads_on = 1'b1;
      live();
      rdst();
      exp.leads_on = 1'b0;
      live();
      @(posedge clock);
      src.leads_on_raw <= 1'b1;
      exp.leads_on = 1'b1;
      live();
      @(posedge clock);
      src.leads_on_raw <= 1'b0;
      rdst();
      exp.leads_on = 1'b0;
      @(posedge clock);
      cfg.ulp_leads_on_mode <= 2'h0;
      live();
    end
    @(posedge clock);
    cfg.fast_clear_select <= 1'b1;
    src.fast_active <= 1'b1;
    exp.fast = 1'b1;
    live();
    rdst();
    exp.fast = 1'b0;
    live();
    @(posedge clock);
    src.fast_active <= 1'b0;
    cyc(2);
    src.fast_active <= 1'b1;
    exp.fast = 1'b1;
    live();
    @(posedge clock);
    cfg.fast_clear_select <= 1'b0;
    rdst();
    live();
    @(posedge clock);
    src.fast_active <= 1'b0;
    live();
    rdst();
    exp.fast = 1'b0;
    live();
    stop_test();
  end
endmodule
